// ---- mcv_defines.svh ----
// constants for the management message validator and its sender
// assumes inclusion by bare name from both ends
`ifndef MCV_DEFINES_SVH
`define MCV_DEFINES_SVH
`define MCV_MAX_LEN 6'd32
`define MCV_MIN_LEN 6'd4
`define MCV_CODE_BYTE 0
`define MCV_TAG_HI 2
`define MCV_TAG_LO 3
`define MCV_ULP_BASE 8'h80
`define MCV_PRIV_HI 8'h0F
`define MCV_APP_LO 8'h20
`define MCV_APP_HI 8'h23
`define MCV_NODE_QUERY 8'h00
`define MCV_NODE_QUERY_REPLY 8'h01
`define MCV_PORT_CONFIGURE 8'h02
`define MCV_RESPONSE 8'h03
`define MCV_ASYNC_ALERT 8'h04
`define MCV_MASTER_ALERT 8'h05
`define MCV_MSG_A 8'h06
`define MCV_ASYNC_REPLY 8'h07
`define MCV_PROTO_QUERY 8'h08
`define MCV_PROTO_REPLY 8'h09
`define MCV_PORT_QUERY 8'h0A
`define MCV_PORT_REPLY 8'h0B
`define MCV_SWITCH_QUERY 8'h0C
`define MCV_SWITCH_REPLY 8'h0D
`define MCV_SAT_REQUEST 8'h0E
`define MCV_SAT_REPLY 8'h0F
`define MCV_UNKNOWN_MESSAGE_ALERT 24'h020100
`define MCV_SHORT_MESSAGE_ALERT 24'h020300
`define MCV_UNSUPPORTED_PROTOCOL_ALERT 24'h020400
`define MCV_OVERLAP_RETURN_CODE 8'h01
`define MCV_INVALID_FIELD_CODE 8'h02
`define MCV_PATH_OFS 4
`define MCV_PATH_LEN 4
`define MCV_EXTEND_BIT 7
`define MCV_RSVD_BYTES 32'h0000_0080
`define MCV_SRC_CFG 0
`define MCV_SRC_MASTER 1
`define MCV_CLK_HZ 50000000
`define MCV_NQ_TIMEOUT_MS 10
`endif

// ---- mcv_pkg.sv ----
// types shared by both ends of the management message link
// assumes mcv_defines.svh is on the include path
package mcv_pkg;
    typedef logic [7:0] mcv_byte_type;
    typedef logic [31:0][7:0] mcv_msg_type;
    typedef enum logic [0:0] {V_RX, V_CHECK} mcv_vstate_type;
    typedef enum logic [0:0] {S_IDLE, S_SEND} mcv_sstate_type;
    typedef struct packed {
        mcv_vstate_type st;
        mcv_msg_type buffer;
        logic [5:0] len;
        logic over;
        logic priv;
        logic [1:0] src;
        logic [7:0] src_id;
        logic outst;
        logic [7:0] outst_id;
        logic ready;
        logic alert_v;
        logic [23:0] alert;
        logic resp_v;
        logic [7:0] resp_code;
        logic [15:0] resp_tag;
        logic del_v;
        mcv_msg_type del_data;
        logic [5:0] del_len;
        logic ulp_v;
    } mcv_vreg_type;
    typedef struct packed {
        mcv_sstate_type st;
        mcv_msg_type buffer;
        logic [5:0] len;
        logic [5:0] total;
        logic [5:0] idx;
        logic priv;
        logic [1:0] src;
        logic [7:0] src_id;
        logic nq_wait;
        logic [31:0] timer;
        logic [15:0] tag;
        logic data_xfer;
        logic vld;
        mcv_byte_type data;
        logic last;
        logic busy;
        logic err_log;
        logic abort_ulp;
        logic alert_seen;
        logic [23:0] alert;
    } mcv_sreg_type;
endpackage

// ---- mcv_link_if.sv ----
// byte stream link from a sending node to a validating node
// assumes both ends share mclk; no clocking here
`timescale 1ns/1ps
`default_nettype none
interface mcv_link_if;
    logic msg_valid;
    logic msg_ready;
    logic [7:0] msg_byte;
    logic msg_last;
    logic msg_priv;
    logic [1:0] msg_src_type;
    logic [7:0] msg_src_id;
    logic alert_valid;
    logic [23:0] alert_code;
    logic resp_valid;
    logic [7:0] resp_code;
    logic [15:0] resp_tag;
    modport host (output msg_valid, msg_byte, msg_last, msg_priv,
        msg_src_type, msg_src_id, input msg_ready, alert_valid,
        alert_code, resp_valid, resp_code, resp_tag);
    modport device (input msg_valid, msg_byte, msg_last, msg_priv,
        msg_src_type, msg_src_id, output msg_ready, alert_valid,
        alert_code, resp_valid, resp_code, resp_tag);
endinterface
`default_nettype wire

// ---- mcv_validator.sv ----
// device end: collects a management message and validates it
// assumes the sender holds bytes until msg_ready; inputs on mclk
// Operation
// - code byte 0, tag bytes 2 and 3
// - over 32 bytes is never valid for codes below 80h
// - padding with zero bytes reaches exactly 32 bytes
// - pad bytes are counted, delivered and checked like data
// - path bytes after zero extend flag zeroed on delivery of codes below 80h; byte 7 still reserved-checked
// - codes 00h-0Fh privileged, 10h-1Fh invalid
// - codes 20h-23h application, 24h-7Fh invalid
// - supported protocol codes pass without frame check
// - unsupported protocol codes raise protocol alert
// - invalid codes raise unknown message alert
// - wrong frame or node type: unknown alert
// - overlapping outstanding request gets overlap response
// - node query without storage dropped silently
// - configuration node retries node query on timeout
// - continue only on full table match
// - too few bytes raise short message alert
// - alert abandons message, no other response
// - reply route need not be registered
// - reserved field errors answered, except 00h/01h
// - bad tag logged by configurator, which also raises abort_ulp when the message sent was 20h-23h
// - alert code is type, subtype, information
`include "mcv_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mcv_validator #(
    parameter logic [31:0] RSVD_BYTES = `MCV_RSVD_BYTES
) (
    input wire logic mclk,
    input wire logic arst_n,
    mcv_link_if.device lk,
    input wire logic local_is_cfg,
    input wire logic local_is_master,
    input wire logic ulp_supported,
    input wire logic storage_free,
    input wire logic request_done,
    output logic deliver_valid,
    output mcv_pkg::mcv_msg_type deliver_data,
    output logic [5:0] deliver_len,
    output logic ulp_valid
);
    import mcv_pkg::*;

    mcv_vreg_type s;
    mcv_vreg_type n;

    function automatic logic code_known(input logic [7:0] c,
                                        input logic priv);
        code_known = 1'b0;
        if (c <= `MCV_PRIV_HI) begin
            code_known = priv;
        end else if (c >= `MCV_APP_LO && c <= `MCV_APP_HI) begin
            code_known = !priv;
        end
    endfunction

    function automatic logic node_ok(input logic [7:0] c,
                                     input logic [1:0] src,
                                     input logic cfg,
                                     input logic mst);
        logic from_ok;
        logic to_ok;
        from_ok = 1'b1;
        to_ok = 1'b1;
        case (c)
            `MCV_NODE_QUERY, `MCV_MSG_A, `MCV_PROTO_QUERY,
            `MCV_PORT_QUERY, `MCV_SWITCH_QUERY: begin
                from_ok = src[`MCV_SRC_CFG];
            end
            `MCV_PORT_CONFIGURE, `MCV_ASYNC_REPLY: begin
                from_ok = src[`MCV_SRC_MASTER];
            end
            `MCV_NODE_QUERY_REPLY, `MCV_RESPONSE, `MCV_PROTO_REPLY,
            `MCV_PORT_REPLY: begin
                to_ok = cfg;
            end
            `MCV_MASTER_ALERT, `MCV_SAT_REPLY: begin
                from_ok = src[`MCV_SRC_MASTER];
                to_ok = cfg;
            end
            `MCV_ASYNC_ALERT: begin
                to_ok = mst;
            end
            `MCV_SAT_REQUEST: begin
                from_ok = src[`MCV_SRC_CFG];
                to_ok = mst;
            end
            default: begin
                from_ok = 1'b1;
            end
        endcase
        node_ok = from_ok && to_ok;
    endfunction

    function automatic logic overlap_class(input logic [7:0] c);
        overlap_class = (c == `MCV_PORT_CONFIGURE) ||
            (c == `MCV_MASTER_ALERT) || (c == `MCV_PORT_QUERY) ||
            (c == `MCV_PROTO_QUERY) || (c == `MCV_MSG_A);
    endfunction

    function automatic logic rsvd_bad(input mcv_msg_type m,
                                      input logic [5:0] len);
        rsvd_bad = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (RSVD_BYTES[i] && 6'(i) < len && m[i] != 8'h00) begin
                rsvd_bad = 1'b1;
            end
        end
    endfunction

    function automatic mcv_msg_type path_mask(input mcv_msg_type m);
        logic ended;
        path_mask = m;
        ended = 1'b0;
        for (int k = 0; k < `MCV_PATH_LEN; k++) begin
            if (ended) begin
                path_mask[`MCV_PATH_OFS + k] = 8'h00;
            end
            if (!m[`MCV_PATH_OFS + k][`MCV_EXTEND_BIT]) begin
                ended = 1'b1;
            end
        end
    endfunction

    always_comb begin
        logic [7:0] c;
        logic [15:0] tag;
        c = s.buffer[`MCV_CODE_BYTE];
        tag = {s.buffer[`MCV_TAG_HI], s.buffer[`MCV_TAG_LO]};
        n = s;
        n.alert_v = 1'b0;
        n.resp_v = 1'b0;
        n.del_v = 1'b0;
        n.ulp_v = 1'b0;
        if (request_done) begin
            n.outst = 1'b0;
        end
        case (s.st)
            V_RX: begin
                n.ready = 1'b1;
                if (lk.msg_valid && s.ready) begin
                    if (s.len == 6'd0) begin
                        n.priv = lk.msg_priv;
                        n.src = lk.msg_src_type;
                        n.src_id = lk.msg_src_id;
                    end
                    if (s.len < `MCV_MAX_LEN) begin
                        n.buffer[s.len[4:0]] = lk.msg_byte;
                        n.len = s.len + 6'd1;
                    end else begin
                        n.over = 1'b1;
                    end
                    if (lk.msg_last) begin
                        n.st = V_CHECK;
                        n.ready = 1'b0;
                    end
                end
            end
            V_CHECK: begin
                n.st = V_RX;
                n.ready = 1'b1;
                n.len = 6'd0;
                n.over = 1'b0;
                n.alert = `MCV_UNKNOWN_MESSAGE_ALERT;
                n.resp_tag = tag;
                // first failing check ends the message
                if (c >= `MCV_ULP_BASE) begin
                    if (ulp_supported) begin
                        n.ulp_v = 1'b1;
                        n.del_v = 1'b1;
                        n.del_data = s.buffer;
                        n.del_len = s.len;
                    end else begin
                        n.alert_v = 1'b1;
                        n.alert = `MCV_UNSUPPORTED_PROTOCOL_ALERT;
                    end
                end else if (s.over || !code_known(c, s.priv)) begin
                    n.alert_v = 1'b1;
                end else if (!node_ok(c, s.src, local_is_cfg,
                                      local_is_master)) begin
                    n.alert_v = 1'b1;
                end else if (overlap_class(c) && s.outst &&
                             s.outst_id == s.src_id) begin
                    n.resp_v = 1'b1;
                    n.resp_code = `MCV_OVERLAP_RETURN_CODE;
                end else if (c == `MCV_NODE_QUERY && !storage_free) begin
                    n.st = V_RX;
                end else if (s.len < `MCV_MIN_LEN) begin
                    n.alert_v = 1'b1;
                    n.alert = `MCV_SHORT_MESSAGE_ALERT;
                end else if (c > `MCV_NODE_QUERY_REPLY &&
                             rsvd_bad(s.buffer, s.len)) begin
                    n.resp_v = 1'b1;
                    n.resp_code = `MCV_INVALID_FIELD_CODE;
                end else begin
                    // reply route is not looked up
                    n.del_v = 1'b1;
                    n.del_data = path_mask(s.buffer);
                    n.del_len = s.len;
                    if (overlap_class(c)) begin
                        n.outst = 1'b1;
                        n.outst_id = s.src_id;
                    end
                end
            end
            default: begin
                n.st = V_RX;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign lk.msg_ready = s.ready;
    assign lk.alert_valid = s.alert_v;
    assign lk.alert_code = s.alert;
    assign lk.resp_valid = s.resp_v;
    assign lk.resp_code = s.resp_code;
    assign lk.resp_tag = s.resp_tag;
    assign deliver_valid = s.del_v;
    assign deliver_data = s.del_data;
    assign deliver_len = s.del_len;
    assign ulp_valid = s.ulp_v;
endmodule
`default_nettype wire

// ---- mcv_sender.sv ----
// far end: sends management messages and checks the answers
// assumes user inputs on mclk and the device end on the same clock
`include "mcv_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mcv_sender #(
    parameter int NQ_TIMEOUT_CYC = `MCV_NQ_TIMEOUT_MS *
        (`MCV_CLK_HZ / 1000)
) (
    input wire logic mclk,
    input wire logic arst_n,
    mcv_link_if.host lk,
    input wire logic send_start,
    input wire mcv_pkg::mcv_msg_type send_data,
    input wire logic [5:0] send_len,
    input wire logic send_pad,
    input wire logic send_priv,
    input wire logic [1:0] send_src_type,
    input wire logic [7:0] send_src_id,
    input wire logic nq_reply,
    output logic busy,
    output logic err_log,
    output logic abort_ulp,
    output logic alert_seen,
    output logic [23:0] alert_code
);
    import mcv_pkg::*;

    mcv_sreg_type s;
    mcv_sreg_type n;

    always_comb begin
        n = s;
        n.err_log = 1'b0;
        n.abort_ulp = 1'b0;
        n.alert_seen = 1'b0;
        if (lk.alert_valid) begin
            n.alert_seen = 1'b1;
            n.alert = lk.alert_code;
        end
        if (lk.resp_valid && lk.resp_tag != s.tag) begin
            n.err_log = 1'b1;
            n.abort_ulp = s.data_xfer;
        end
        if (s.nq_wait) begin
            if (nq_reply) begin
                n.nq_wait = 1'b0;
            end else if (s.timer == 32'h0000_0000) begin
                n.st = S_SEND;
                n.idx = 6'd0;
                n.nq_wait = 1'b0;
            end else begin
                n.timer = s.timer - 32'h0000_0001;
            end
        end
        case (s.st)
            S_IDLE: begin
                if (send_start && !s.busy) begin
                    n.st = S_SEND;
                    n.buffer = send_data;
                    n.len = (send_len > `MCV_MAX_LEN) ? `MCV_MAX_LEN
                        : send_len;
                    n.total = send_pad ? `MCV_MAX_LEN : n.len;
                    n.idx = 6'd0;
                    n.priv = send_priv;
                    n.src = send_src_type;
                    n.src_id = send_src_id;
                    n.tag = {send_data[`MCV_TAG_HI],
                        send_data[`MCV_TAG_LO]};
                    n.data_xfer = send_data[`MCV_CODE_BYTE] >=
                        `MCV_APP_LO && send_data[`MCV_CODE_BYTE] <=
                        `MCV_APP_HI;
                end
            end
            S_SEND: begin
                if (!s.vld || lk.msg_ready) begin
                    if (s.idx == s.total) begin
                        n.vld = 1'b0;
                        n.st = S_IDLE;
                        if (s.buffer[`MCV_CODE_BYTE] == `MCV_NODE_QUERY)
                        begin
                            n.nq_wait = 1'b1;
                            n.timer = 32'(NQ_TIMEOUT_CYC);
                        end
                    end else begin
                        n.vld = 1'b1;
                        n.data = (s.idx < s.len) ?
                            s.buffer[s.idx[4:0]] : 8'h00;
                        n.last = (s.idx + 6'd1) == s.total;
                        n.idx = s.idx + 6'd1;
                    end
                end
            end
            default: begin
                n.st = S_IDLE;
            end
        endcase
        n.busy = (n.st != S_IDLE) || n.nq_wait || (s.st == S_IDLE &&
            send_start && !s.busy);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign lk.msg_valid = s.vld;
    assign lk.msg_byte = s.data;
    assign lk.msg_last = s.last;
    assign lk.msg_priv = s.priv;
    assign lk.msg_src_type = s.src;
    assign lk.msg_src_id = s.src_id;
    assign busy = s.busy;
    assign err_log = s.err_log;
    assign abort_ulp = s.abort_ulp;
    assign alert_seen = s.alert_seen;
    assign alert_code = s.alert;
endmodule
`default_nettype wire

// ---- mcv_link_properties.sv ----
// concurrent checks on the management message link
// assumes the link signals with mclk and arst_n of the nodes
`timescale 1ns/1ps
`default_nettype none
module mcv_link_properties (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic msg_valid,
    input wire logic msg_ready,
    input wire logic [7:0] msg_byte,
    input wire logic msg_last,
    input wire logic alert_valid,
    input wire logic [23:0] alert_code,
    input wire logic resp_valid,
    input wire logic [7:0] resp_code,
    input wire logic [15:0] resp_tag
);
    logic take;
    logic fin;
    logic [5:0] idx;
    logic [7:0] code;
    logic [7:0] cur;
    logic [15:0] tag;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    assign take = msg_valid && msg_ready;
    assign fin = take && msg_last;
    assign cur = (idx == 6'h00) ? msg_byte : code;
    // byte position, code and tag of the message in flight
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            idx <= 6'h00;
            code <= 8'h00;
            tag <= 16'h0000;
        end else if (take) begin
            idx <= msg_last ? 6'h00 : idx + 6'h01;
            if (idx == 6'h00) code <= msg_byte;
            if (idx == 6'h02) tag[15:8] <= msg_byte;
            if (idx == 6'h03) tag[7:0] <= msg_byte;
        end
    end
    a_result_after_last: assert property (
        (alert_valid || resp_valid) |-> $past(fin, 2))
        else $error("result not two cycles after last byte");
    a_ready_drop_check: assert property (fin |=> !msg_ready)
        else $error("ready not dropped for check cycle");
    a_single_result: assert property (
        !(alert_valid && resp_valid))
        else $error("alert and response together");
    a_reserved_code_unknown: assert property (
        fin && (cur inside {[8'h10:8'h1F], [8'h24:8'h7F]}) |->
        ##2 alert_valid && alert_code == 24'h020100)
        else $error("reserved code without unknown alert");
    a_protocol_code_path: assert property (
        fin && cur >= 8'h80 |->
        ##2 !resp_valid && (!alert_valid || alert_code == 24'h020400))
        else $error("protocol code handled wrongly");
    a_alert_code_form: assert property (
        alert_valid |-> alert_code[23:16] == 8'h02 &&
        alert_code[7:0] == 8'h00)
        else $error("alert code malformed");
    a_resp_tag_match: assert property (
        resp_valid |-> resp_tag == tag && resp_code inside {8'h01, 8'h02})
        else $error("response tag or code wrong");
    a_query_no_resp: assert property (
        fin && cur <= 8'h01 |-> ##2 !resp_valid)
        else $error("response to node query");
    a_length_limit: assert property (take |-> idx < 6'd32)
        else $error("message longer than 32 bytes");
    a_byte_held: assert property (
        msg_valid && !msg_ready |=> msg_valid && $stable(msg_byte))
        else $error("byte changed before taken");
    c_alert: cover property (alert_valid);
    c_resp: cover property (resp_valid);
    c_silent: cover property (fin ##2 !alert_valid && !resp_valid);
endmodule
`default_nettype wire

// ---- message_code_validator_tb.sv ----
// self-checking bench: sender and validator joined by the link
// assumes both design ends, the link interface and the checker
`timescale 1ns/1ps
`default_nettype none
module message_code_validator_tb;
    import mcv_pkg::*;
    logic mclk, arst_n, cfg, mst, ulp_sup, stor, rq_done;
    logic start, pad, priv, nq_reply, d_valid, u_valid, busy;
    logic err_log, abort_ulp, a_seen;
    logic [1:0] src;
    logic [7:0] sid;
    logic [5:0] len, d_len;
    logic [23:0] s_alert;
    logic [31:0] res;
    mcv_msg_type data, d_data;
    int n_res, n_last, n_err, n_seen, n_mismatch, samples_checked, i;
    logic [7:0] rc [4] = '{8'h10, 8'h1F, 8'h24, 8'h7F};
    logic [7:0] oc [5] = '{8'h02, 8'h05, 8'h06, 8'h08, 8'h0A};
    mcv_link_if lk ();
    mcv_validator mcv_validator_i (.mclk(mclk), .arst_n(arst_n), .lk(lk),
        .local_is_cfg(cfg), .local_is_master(mst), .ulp_supported(ulp_sup),
        .storage_free(stor), .request_done(rq_done),
        .deliver_valid(d_valid), .deliver_data(d_data),
        .deliver_len(d_len), .ulp_valid(u_valid));
    mcv_sender #(.NQ_TIMEOUT_CYC(40)) mcv_sender_i (.mclk(mclk),
        .arst_n(arst_n), .lk(lk), .send_start(start), .send_data(data),
        .send_len(len), .send_pad(pad), .send_priv(priv),
        .send_src_type(src), .send_src_id(sid), .nq_reply(nq_reply),
        .busy(busy), .err_log(err_log), .abort_ulp(abort_ulp),
        .alert_seen(a_seen), .alert_code(s_alert));
    mcv_link_properties mcv_link_properties_i (.mclk(mclk),
        .arst_n(arst_n), .msg_valid(lk.msg_valid),
        .msg_ready(lk.msg_ready), .msg_byte(lk.msg_byte),
        .msg_last(lk.msg_last), .alert_valid(lk.alert_valid),
        .alert_code(lk.alert_code), .resp_valid(lk.resp_valid),
        .resp_code(lk.resp_code), .resp_tag(lk.resp_tag));
    always #10 mclk = ~mclk;
    // collects every result the validator gives
    always @(posedge mclk) begin
        if (lk.msg_valid && lk.msg_ready && lk.msg_last) n_last <= n_last + 1;
        n_err <= n_err + int'(err_log) + int'(abort_ulp);
        if (a_seen) n_seen <= n_seen + 1;
        n_res <= n_res + int'(lk.alert_valid) + int'(lk.resp_valid)
            + int'(d_valid);
        if (lk.alert_valid) res <= {8'h01, lk.alert_code};
        if (lk.resp_valid) res <= {8'h02, lk.resp_code, lk.resp_tag};
        if (d_valid) res <= {u_valid ? 8'h04 : 8'h03, 18'h0, d_len};
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic send(input logic [7:0] c, input logic [5:0] n,
        input logic pv, input logic [1:0] st, input int p,
        input logic [7:0] x, input logic [31:0] exp);
        int n0, l0, k, s0;
        n0 = n_res;
        s0 = n_seen;
        l0 = n_last;
        res = 32'h0;
        data = '0;
        data[0] = c;
        data[2] = 8'hA5;
        data[3] = c;
        data[p] = x;
        len = n;
        priv = pv;
        src = st;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        for (k = 0; k < 200 && n_last == l0; k++) @(negedge mclk);
        repeat (4) @(negedge mclk);
        if (c == 8'h00 && stor) begin
            nq_reply = 1'b1;
            @(negedge mclk);
            nq_reply = 1'b0;
        end
        if (c != 8'h00 || stor) begin
            for (k = 0; k < 200 && busy !== 1'b0; k++) @(negedge mclk);
        end
        chk(res, exp);
        chk(32'(n_res - n0), (exp == 32'h0) ? 32'h0 : 32'h1);
        if (exp[31:24] == 8'h01) chk({8'h01, s_alert}, exp);
        chk(32'(n_seen - s0), {31'h0, exp[31:24] == 8'h01});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #80000;
        n_mismatch++;
        summarize();
    end
    initial begin
        mclk = 0; arst_n = 0; cfg = 1; mst = 1; ulp_sup = 1; stor = 1;
        rq_done = 0; start = 0; pad = 0; priv = 1; nq_reply = 0;
        src = 2'b11; sid = 8'h05; len = 6'h04; data = '0; res = 0;
        n_res = 0; n_last = 0; n_err = 0; n_mismatch = 0; n_seen = 0;
        samples_checked = 0;
        repeat (5) @(negedge mclk);
        arst_n = 1;
        @(negedge mclk);
        send(8'h80, 6'h08, 1'b0, 2'b11, 7, 8'h00, 32'h0400_0008);
        ulp_sup = 0;
        send(8'hC3, 6'h08, 1'b1, 2'b11, 7, 8'h00, 32'h0102_0400);
        ulp_sup = 1;
        foreach (rc[j]) send(rc[j], 6'h08, rc[j] < 8'h20, 2'b11, 7, 8'h00,
            32'h0102_0100);
        for (i = 0; i < 4; i++) send(8'(8'h20 + i), 6'h08, 1'b0, 2'b11, 7,
            8'h00, 32'h0300_0008);
        send(8'h21, 6'h08, 1'b1, 2'b11, 7, 8'h00, 32'h0102_0100);
        send(8'h02, 6'h08, 1'b1, 2'b01, 7, 8'h00, 32'h0102_0100);
        cfg = 0;
        send(8'h03, 6'h08, 1'b1, 2'b11, 7, 8'h00, 32'h0102_0100);
        cfg = 1;
        mst = 0;
        send(8'h04, 6'h08, 1'b1, 2'b11, 7, 8'h00, 32'h0102_0100);
        mst = 1;
        foreach (oc[j]) begin
            send(oc[j], 6'h08, 1'b1, 2'b11, 7, 8'h00, 32'h0300_0008);
            send(oc[j], 6'h08, 1'b1, 2'b11, 7, 8'h00,
                {16'h0201, 8'hA5, oc[j]});
            rq_done = 1'b1;
            @(negedge mclk);
            rq_done = 1'b0;
        end
        send(8'h03, 6'h03, 1'b1, 2'b11, 7, 8'h00, 32'h0102_0300);
        send(8'h03, 6'h08, 1'b1, 2'b11, 7, 8'h01, 32'h0202_A503);
        send(8'h01, 6'h08, 1'b1, 2'b11, 7, 8'h01, 32'h0300_0008);
        pad = 1;
        send(8'h03, 6'h04, 1'b1, 2'b11, 7, 8'h55, 32'h0300_0020);
        chk({d_data[31], d_data[7]}, 32'h0);
        pad = 0;
        send(8'h03, 6'h08, 1'b1, 2'b11, 5, 8'hAB, 32'h0300_0008);
        chk({d_data[5], d_data[0]}, 32'h0003);
        send(8'h00, 6'h04, 1'b1, 2'b01, 7, 8'h00, 32'h0300_0004);
        stor = 0;
        send(8'h00, 6'h04, 1'b1, 2'b01, 7, 8'h00, 32'h0);
        i = n_last;
        repeat (60) @(negedge mclk);
        chk(32'(n_last - i), 32'h1);
        stor = 1;
        nq_reply = 1'b1;
        @(negedge mclk);
        nq_reply = 1'b0;
        for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge mclk);
        // a new send before the answer leaves a stale tag behind
        data = '0;
        data[0] = 8'h03;
        data[2] = 8'hA5;
        data[3] = 8'h03;
        data[7] = 8'h01;
        len = 6'h08;
        priv = 1'b1;
        i = n_last;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        while (n_last == i) @(negedge mclk);
        data[0] = 8'h20;
        data[3] = 8'h20;
        priv = 1'b0;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge mclk);
        chk(32'(n_err), 32'h2);
        summarize();
    end
endmodule
`default_nettype wire
